// [pkg/crt_pkg.sv]
/*
 * Constants, register map and state codes of the clock, reset and
 * output 3-state controller.
 * Assumes a single 10 MHz clock and a classic Wishbone master.
 */

package crt_pkg;

    // ----------------------------------------------------------------
    // Widths and timing
    // ----------------------------------------------------------------
    localparam int          PC_W_DEF       = 24;
    localparam int          REG_W          = 16;
    localparam int          DAT_W          = 32;
    localparam int          ADR_W          = 6;
    localparam int          CLK_PERIOD_NS  = 100;

    // ----------------------------------------------------------------
    // Register byte addresses
    // ----------------------------------------------------------------
    localparam logic [5:0]  ADR_STATUS     = 6'h00;
    localparam logic [5:0]  ADR_PC         = 6'h04;
    localparam logic [5:0]  ADR_SAVED      = 6'h08;
    localparam logic [5:0]  ADR_SIO_CFG    = 6'h0C;
    localparam logic [5:0]  ADR_ERR_STAT   = 6'h10;
    localparam logic [5:0]  ADR_ERR_MASK   = 6'h14;
    localparam logic [5:0]  ADR_PAR_CTRL   = 6'h18;
    localparam logic [5:0]  ADR_WAIT_CTRL  = 6'h1C;
    localparam logic [5:0]  ADR_COND_FLAGS = 6'h20;
    localparam logic [5:0]  ADR_FLOAT_CTRL = 6'h24;

    // ----------------------------------------------------------------
    // Values loaded by the reset sequence
    // ----------------------------------------------------------------
    localparam logic [15:0] ERR_MASK_ALL   = 16'hFFFF;
    localparam logic [15:0] PAR_CTRL_INIT  = 16'h0001;
    localparam logic [15:0] WAIT_CTRL_INIT = 16'h0002;
    localparam logic [15:0] REG_CLEAR      = 16'h0000;

    // ----------------------------------------------------------------
    // Status register fields
    // ----------------------------------------------------------------
    localparam int          STAT_STATE_LSB = 0;
    localparam int          STAT_TRI_BIT   = 2;
    localparam int          STAT_RUN_BIT   = 3;

    // ----------------------------------------------------------------
    // Run/halt states
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_HALT = 2'b00,
        ST_SAVE = 2'b01,
        ST_INIT = 2'b10,
        ST_RUN  = 2'b11
    } crt_state_e;

endpackage

// [design/crt_sync.sv]
/*
 * Two-flop synchroniser for a vector of pin inputs.
 * Assumes each bit is an independent level from outside the clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module crt_sync #(
    parameter int               WIDTH   = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_n_in,
    // Data
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    if (WIDTH < 1)
    begin : g_bad_width
        $error("WIDTH must be at least 1");
    end

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] nxt_meta;
    logic [WIDTH-1:0] nxt_sync;

    always_comb
    begin
        nxt_meta = rst_n_in ? async_in : RST_VAL;
        nxt_sync = rst_n_in ? meta_ff : RST_VAL;
    end

    always_ff @(posedge ref_clk_in)
    begin
        meta_ff  <= nxt_meta;
        sync_out <= nxt_sync;
    end

endmodule

`default_nettype wire

// [design/crt_wait_ctr.sv]
/*
 * Fetch pacing counter: counts wait states, then waits for ready.
 * Assumes ready_n_in is already synchronised; clr_in restarts the count.
 */
`timescale 1ns/1ps
`default_nettype none

module crt_wait_ctr #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input  wire logic             ref_clk_in,
    input  wire logic             rst_n_in,
    // Control
    input  wire logic             clr_in,
    input  wire logic [CNT_W-1:0] waits_in,
    input  wire logic             ready_n_in,
    output logic                  done_out
);

    if (CNT_W < 1)
    begin : g_bad_cnt_w
        $error("CNT_W must be at least 1");
    end

    logic [CNT_W-1:0] cnt_ff;
    logic [CNT_W-1:0] nxt_cnt;
    logic             reached;

    always_comb
    begin
        reached  = (cnt_ff >= waits_in);
        // Extra waits come only from a late ready
        done_out = reached && !ready_n_in && !clr_in;
        nxt_cnt  = cnt_ff;
        if (!rst_n_in || clr_in || done_out)
        begin
            nxt_cnt = '0;
        end
        else if (!reached)
        begin
            nxt_cnt = cnt_ff + CNT_W'(1);
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        cnt_ff <= nxt_cnt;
    end

endmodule

`default_nettype wire

// [design/crt_ctrl.sv]
/*
 * Clock buffering, run/halt reset sequencing and global output
 * 3-state control, with its state registers on a Wishbone slave.
 * Assumes the master clock is much slower than ref_clk_in, and that
 * the board ties a pull-up on the 3-state pin outside this logic.
 */
`timescale 1ns/1ps
`default_nettype none

module crt_ctrl #(
    parameter int PC_W = crt_pkg::PC_W_DEF
) (
    // Clock and reset
    input  wire logic                      ref_clk_in,
    input  wire logic                      rst_n_in,
    // Wishbone slave
    input  wire logic                      wb_cyc_in,
    input  wire logic                      wb_stb_in,
    input  wire logic                      wb_we_in,
    input  wire logic [crt_pkg::ADR_W-1:0] wb_adr_in,
    input  wire logic [3:0]                wb_sel_in,
    input  wire logic [crt_pkg::DAT_W-1:0] wb_dat_in,
    output logic                           wb_ack_out,
    output logic      [crt_pkg::DAT_W-1:0] wb_dat_out,
    // Device pins
    input  wire logic                      master_clock_in,
    input  wire logic                      halt_reset_n_in,
    input  wire logic                      tristate_all_n_in,
    input  wire logic                      sync_ready_n_in,
    output logic                           buffered_clock_out,
    output logic                           buffered_clock_oe_n_out,
    // Instruction fetch
    output logic      [PC_W-1:0]           fetch_addr_out,
    output logic                           fetch_strobe_out,
    output logic                           fetch_oe_n_out,
    output logic                           halted_out
);

    // ----------------------------------------------------------------
    // Parameter check
    // ----------------------------------------------------------------
    if (PC_W < 2 || PC_W > crt_pkg::DAT_W)
    begin : g_bad_pc_w
        $error("PC_W must lie between 2 and the bus width");
    end

    localparam int RW = crt_pkg::REG_W;

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    logic [3:0] pins_sync;
    logic       mclk_s;
    logic       halt_n_s;
    logic       tri_n_s;
    logic       rdy_n_s;

    // 3-state and ready idle inactive; halt idles low, so no false rise
    crt_sync #(
        .WIDTH   (4),
        .RST_VAL (4'hC)
    ) u_sync (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .async_in   ({sync_ready_n_in, tristate_all_n_in, halt_reset_n_in,
                      master_clock_in}),
        .sync_out   (pins_sync)
    );

    assign mclk_s   = pins_sync[0];
    assign halt_n_s = pins_sync[1];
    assign tri_n_s  = pins_sync[2];
    assign rdy_n_s  = pins_sync[3];

    // ----------------------------------------------------------------
    // State and registers
    // ----------------------------------------------------------------
    crt_pkg::crt_state_e state_ff;
    crt_pkg::crt_state_e nxt_state;
    logic                halt_prev_ff;
    logic                nxt_halt_prev;
    logic [PC_W-1:0]     pc_ff;
    logic [PC_W-1:0]     nxt_pc;
    logic [PC_W-1:0]     saved_ff;
    logic [PC_W-1:0]     nxt_saved;
    logic [RW-1:0]       sio_cfg_ff;
    logic [RW-1:0]       nxt_sio_cfg;
    logic [RW-1:0]       err_stat_ff;
    logic [RW-1:0]       nxt_err_stat;
    logic [RW-1:0]       err_mask_ff;
    logic [RW-1:0]       nxt_err_mask;
    logic [RW-1:0]       par_ctrl_ff;
    logic [RW-1:0]       nxt_par_ctrl;
    logic [RW-1:0]       wait_ctrl_ff;
    logic [RW-1:0]       nxt_wait_ctrl;
    logic [RW-1:0]       cond_ff;
    logic [RW-1:0]       nxt_cond;
    logic [RW-1:0]       fctrl_ff;
    logic [RW-1:0]       nxt_fctrl;

    // Bus side
    logic                       wr_go;
    logic [crt_pkg::DAT_W-1:0]  wr_val;
    logic [crt_pkg::DAT_W-1:0]  rd_val;
    logic                       nxt_ack;
    logic [crt_pkg::DAT_W-1:0]  nxt_rdat;

    // Fetch pacing
    logic                       fetch_done;
    logic                       run_clr;

    function automatic logic [crt_pkg::DAT_W-1:0] merge_lanes(
        input logic [crt_pkg::DAT_W-1:0] old_v,
        input logic [crt_pkg::DAT_W-1:0] new_v,
        input logic [3:0]                sel
    );
        logic [crt_pkg::DAT_W-1:0] res;
        res = old_v;
        for (int i = 0; i < 4; i++)
        begin
            if (sel[i])
            begin
                res[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // ----------------------------------------------------------------
    // Wishbone decode
    // ----------------------------------------------------------------
    // Write lands at the edge where ack is sampled high
    assign wr_go = wb_cyc_in && wb_stb_in && wb_we_in && wb_ack_out;

    always_comb
    begin
        rd_val = '0;
        case (wb_adr_in)
            crt_pkg::ADR_STATUS:
            begin
                rd_val[crt_pkg::STAT_STATE_LSB +: 2] = state_ff;
                rd_val[crt_pkg::STAT_TRI_BIT]        = !tri_n_s;
                rd_val[crt_pkg::STAT_RUN_BIT]        = (state_ff == crt_pkg::ST_RUN);
            end
            crt_pkg::ADR_PC:         rd_val[PC_W-1:0] = pc_ff;
            crt_pkg::ADR_SAVED:      rd_val[PC_W-1:0] = saved_ff;
            crt_pkg::ADR_SIO_CFG:    rd_val[RW-1:0]   = sio_cfg_ff;
            crt_pkg::ADR_ERR_STAT:   rd_val[RW-1:0]   = err_stat_ff;
            crt_pkg::ADR_ERR_MASK:   rd_val[RW-1:0]   = err_mask_ff;
            crt_pkg::ADR_PAR_CTRL:   rd_val[RW-1:0]   = par_ctrl_ff;
            crt_pkg::ADR_WAIT_CTRL:  rd_val[RW-1:0]   = wait_ctrl_ff;
            crt_pkg::ADR_COND_FLAGS: rd_val[RW-1:0]   = cond_ff;
            crt_pkg::ADR_FLOAT_CTRL: rd_val[RW-1:0]   = fctrl_ff;
            default:                 rd_val           = '0;
        endcase
        // Unmapped addresses still ack, reading zero
        wr_val   = merge_lanes(rd_val, wb_dat_in, wb_sel_in);
        nxt_ack  = rst_n_in && wb_cyc_in && wb_stb_in && !wb_ack_out;
        nxt_rdat = rst_n_in ? rd_val : '0;
    end

    always_ff @(posedge ref_clk_in)
    begin
        wb_ack_out <= nxt_ack;
        wb_dat_out <= nxt_rdat;
    end

    // ----------------------------------------------------------------
    // Run/halt sequencer and processor registers
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_state     = state_ff;
        nxt_halt_prev = halt_n_s;
        nxt_pc        = pc_ff;
        nxt_saved     = saved_ff;
        nxt_sio_cfg   = sio_cfg_ff;
        nxt_err_stat  = err_stat_ff;
        nxt_err_mask  = err_mask_ff;
        nxt_par_ctrl  = par_ctrl_ff;
        nxt_wait_ctrl = wait_ctrl_ff;
        nxt_cond      = cond_ff;
        nxt_fctrl     = fctrl_ff;

        // Software writes first; the sequencer overrides below, except that a PC write wins over the RUN step
        if (wr_go)
        begin
            case (wb_adr_in)
                crt_pkg::ADR_PC:         nxt_pc        = wr_val[PC_W-1:0];
                crt_pkg::ADR_SAVED:      nxt_saved     = wr_val[PC_W-1:0];
                crt_pkg::ADR_SIO_CFG:    nxt_sio_cfg   = wr_val[RW-1:0];
                crt_pkg::ADR_ERR_STAT:   nxt_err_stat  = wr_val[RW-1:0];
                crt_pkg::ADR_ERR_MASK:   nxt_err_mask  = wr_val[RW-1:0];
                crt_pkg::ADR_PAR_CTRL:   nxt_par_ctrl  = wr_val[RW-1:0];
                crt_pkg::ADR_WAIT_CTRL:  nxt_wait_ctrl = wr_val[RW-1:0];
                crt_pkg::ADR_COND_FLAGS: nxt_cond      = wr_val[RW-1:0];
                crt_pkg::ADR_FLOAT_CTRL: nxt_fctrl     = wr_val[RW-1:0];
                default:                 nxt_pc        = pc_ff;
            endcase
        end

        case (state_ff)
            crt_pkg::ST_HALT:
            begin
                // Only a rising edge of the halt input starts the sequence
                if (halt_n_s && !halt_prev_ff)
                begin
                    nxt_state = crt_pkg::ST_SAVE;
                end
            end
            crt_pkg::ST_SAVE:
            begin
                nxt_saved = pc_ff;
                nxt_state = crt_pkg::ST_INIT;
            end
            crt_pkg::ST_INIT:
            begin
                // Condition flags and float control left alone
                nxt_pc        = '0;
                nxt_sio_cfg   = crt_pkg::REG_CLEAR;
                nxt_err_stat  = crt_pkg::REG_CLEAR;
                nxt_err_mask  = crt_pkg::ERR_MASK_ALL;
                nxt_par_ctrl  = crt_pkg::PAR_CTRL_INIT;
                nxt_wait_ctrl = crt_pkg::WAIT_CTRL_INIT;
                nxt_cond      = cond_ff;
                nxt_fctrl     = fctrl_ff;
                nxt_state     = crt_pkg::ST_RUN;
            end
            crt_pkg::ST_RUN:
            begin
                if (fetch_done && !(wr_go && wb_adr_in == crt_pkg::ADR_PC))
                begin
                    nxt_pc = pc_ff + PC_W'(1);
                end
            end
            default:
            begin
                nxt_state = crt_pkg::ST_HALT;
            end
        endcase

        // Low halt input wins over every state
        if (!halt_n_s)
        begin
            nxt_state = crt_pkg::ST_HALT;
        end

        if (!rst_n_in)
        begin
            nxt_state     = crt_pkg::ST_HALT;
            nxt_halt_prev = 1'b0;
            nxt_pc        = '0;
            nxt_saved     = '0;
            nxt_sio_cfg   = crt_pkg::REG_CLEAR;
            nxt_err_stat  = crt_pkg::REG_CLEAR;
            nxt_err_mask  = crt_pkg::ERR_MASK_ALL;
            nxt_par_ctrl  = crt_pkg::PAR_CTRL_INIT;
            nxt_wait_ctrl = crt_pkg::WAIT_CTRL_INIT;
            nxt_cond      = crt_pkg::REG_CLEAR;
            nxt_fctrl     = crt_pkg::REG_CLEAR;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        state_ff     <= nxt_state;
        halt_prev_ff <= nxt_halt_prev;
        pc_ff        <= nxt_pc;
        saved_ff     <= nxt_saved;
        sio_cfg_ff   <= nxt_sio_cfg;
        err_stat_ff  <= nxt_err_stat;
        err_mask_ff  <= nxt_err_mask;
        par_ctrl_ff  <= nxt_par_ctrl;
        wait_ctrl_ff <= nxt_wait_ctrl;
        cond_ff      <= nxt_cond;
        fctrl_ff     <= nxt_fctrl;
    end

    // ----------------------------------------------------------------
    // Fetch pacing
    // ----------------------------------------------------------------
    assign run_clr = (state_ff != crt_pkg::ST_RUN) || !halt_n_s;

    crt_wait_ctr #(
        .CNT_W (RW)
    ) u_wait (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .clr_in     (run_clr),
        .waits_in   (wait_ctrl_ff),
        .ready_n_in (rdy_n_s),
        .done_out   (fetch_done)
    );

    // ----------------------------------------------------------------
    // Output pins
    // ----------------------------------------------------------------
    logic            nxt_clk_buf;
    logic            nxt_oe_n;
    logic [PC_W-1:0] nxt_faddr;
    logic            nxt_fstb;
    logic            nxt_halted;

    always_comb
    begin
        // Sampled copy: same frequency, up to three ref cycles late
        nxt_clk_buf = rst_n_in && mclk_s;
        nxt_oe_n    = !rst_n_in || !tri_n_s;
        nxt_faddr   = fetch_done ? pc_ff : fetch_addr_out;
        nxt_fstb    = rst_n_in && fetch_done && !run_clr;
        nxt_halted  = !rst_n_in || (state_ff != crt_pkg::ST_RUN);
        if (!rst_n_in)
        begin
            nxt_faddr = '0;
        end
    end

    always_ff @(posedge ref_clk_in)
    begin
        buffered_clock_out      <= nxt_clk_buf;
        buffered_clock_oe_n_out <= nxt_oe_n;
        fetch_oe_n_out          <= nxt_oe_n;
        fetch_addr_out          <= nxt_faddr;
        fetch_strobe_out        <= nxt_fstb;
        halted_out              <= nxt_halted;
    end

endmodule

`default_nettype wire

// [verification/crt_ctrl_assertions.sv]
/* Port-level checker for crt_ctrl: bus answer, halt, fetch and float.
 * Assumes it is bound into crt_ctrl; one clock domain. */
`timescale 1ns/1ps
`default_nettype none
module crt_ctrl_assertions #(
    parameter int PC_W = crt_pkg::PC_W_DEF
) (
    input wire logic            ref_clk_in,
    input wire logic            rst_n_in,
    input wire logic            wb_cyc_in,
    input wire logic            wb_stb_in,
    input wire logic            wb_ack_out,
    input wire logic            master_clock_in,
    input wire logic            halt_reset_n_in,
    input wire logic            tristate_all_n_in,
    input wire logic            buffered_clock_out,
    input wire logic            buffered_clock_oe_n_out,
    input wire logic [PC_W-1:0] fetch_addr_out,
    input wire logic            fetch_strobe_out,
    input wire logic            fetch_oe_n_out,
    input wire logic            halted_out
);
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic            first_ff;
    logic [PC_W-1:0] last_ff;
    // First fetch after any halt must come from address zero
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in || halted_out)
            first_ff <= 1'b1;
        else if (fetch_strobe_out)
            first_ff <= 1'b0;
        if (fetch_strobe_out)
            last_ff <= fetch_addr_out;
    end
    a_ack_answer:
        assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
            else $error("bus request not answered in one cycle");
    a_clk_follows:
        assert property (buffered_clock_out == $past(master_clock_in, 3))
            else $error("buffered clock does not follow master clock");
    a_halt_on_low:
        assert property (!halt_reset_n_in [*6] |-> halted_out)
            else $error("not halted while halt pin low");
    a_no_fetch_halt:
        assert property (halted_out && $past(halted_out) |-> !fetch_strobe_out)
            else $error("fetch while halted");
    a_run_after_rise:
        assert property ($rose(halt_reset_n_in) ##0 halt_reset_n_in [*8] |-> !halted_out)
            else $error("still halted after reset sequence");
    a_first_fetch_zero:
        assert property (fetch_strobe_out && first_ff |-> fetch_addr_out == '0)
            else $error("first fetch not at address zero");
    a_fetch_step:
        assert property (fetch_strobe_out && !first_ff |-> fetch_addr_out == last_ff + 1'b1)
            else $error("fetch address did not step by one");
    a_two_waits:
        assert property (fetch_strobe_out |=> !fetch_strobe_out [*2])
            else $error("fetches closer than two wait states");
    a_float_all:
        assert property (!tristate_all_n_in [*4] |-> buffered_clock_oe_n_out && fetch_oe_n_out)
            else $error("outputs driven while 3-state active");
    a_drive_idle:
        assert property (tristate_all_n_in [*4] |-> !buffered_clock_oe_n_out && !fetch_oe_n_out)
            else $error("outputs floated while 3-state inactive");
    c_run: cover property ($fell(halted_out));
    c_first: cover property (fetch_strobe_out && first_ff);
    c_float: cover property ($rose(fetch_oe_n_out));
endmodule
`default_nettype wire

// [verification/crt_board_model.sv]
/* Board side: master clock source, halt switch, 3-state pin, ready.
 * Assumes the bench commands each level; clock stands until enabled. */
`timescale 1ns/1ps
`default_nettype none
module crt_board_model (
    input wire logic ref_clk_in,
    input wire logic clk_en_in,
    input wire logic hold_low_in,
    input wire logic float_req_in,
    input wire logic stall_in,
    output var logic master_clock_out,
    output var logic halt_reset_n_out,
    output var logic tristate_all_n_out,
    output var logic sync_ready_n_out
);
    logic [1:0] div_ff;
    // Slow source, well under the sampling limit of the block
    always_ff @(posedge ref_clk_in)
    begin
        div_ff <= clk_en_in ? div_ff + 2'h1 : 2'h0;
        if (!clk_en_in)
            master_clock_out <= 1'b0;
        else if (div_ff == 2'h3)
            master_clock_out <= ~master_clock_out;
    end
    assign halt_reset_n_out   = hold_low_in ? 1'b0 : 1'b1;
    // Released pin floats to the pull-up level
    assign tristate_all_n_out = float_req_in ? 1'b0 : 1'b1;
    assign sync_ready_n_out   = stall_in ? 1'b1 : 1'b0;
endmodule
`default_nettype wire

// [verification/tb_crt_ctrl.sv]
/* Bench for crt_ctrl: Wishbone tasks and sequenced tests.
 * Assumes crt_board_model on the pins and the bound checker. */
`timescale 1ns/1ps
`default_nettype none
module tb_crt_ctrl;
    localparam int PC_W = crt_pkg::PC_W_DEF;
    logic                      ref_clk_in, rst_n_in, wb_cyc, wb_stb, wb_we, wb_ack;
    logic [crt_pkg::ADR_W-1:0] wb_adr;
    logic [3:0]                wb_sel;
    logic [31:0]               wb_wdat, wb_rdat, q;
    logic                      clk_en, hold_low, float_req, stall;
    logic                      mclk, halt_n, tri_n, rdy_n, bclk, bclk_oe_n, f_stb, f_oe_n, halted;
    logic [PC_W-1:0]           f_addr;
    int                        bad_count, n_checks, n_b, n_m, cnt;
    crt_board_model board (.ref_clk_in(ref_clk_in), .clk_en_in(clk_en), .hold_low_in(hold_low),
        .float_req_in(float_req), .stall_in(stall), .master_clock_out(mclk),
        .halt_reset_n_out(halt_n), .tristate_all_n_out(tri_n), .sync_ready_n_out(rdy_n));
    crt_ctrl #(.PC_W(PC_W)) uut (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in),
        .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
        .wb_sel_in(wb_sel), .wb_dat_in(wb_wdat), .wb_ack_out(wb_ack), .wb_dat_out(wb_rdat),
        .master_clock_in(mclk), .halt_reset_n_in(halt_n), .tristate_all_n_in(tri_n),
        .sync_ready_n_in(rdy_n), .buffered_clock_out(bclk), .buffered_clock_oe_n_out(bclk_oe_n),
        .fetch_addr_out(f_addr), .fetch_strobe_out(f_stb), .fetch_oe_n_out(f_oe_n),
        .halted_out(halted));
    initial
    begin
        ref_clk_in = 1'b0;
        forever #(crt_pkg::CLK_PERIOD_NS / 2) ref_clk_in = ~ref_clk_in;
    end
    always @(posedge bclk) n_b++;
    always @(posedge mclk) n_m++;
    task automatic summarize;
        $display("checks=%0d mismatches=%0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        int n;
        @(posedge ref_clk_in);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= a;
        wb_wdat <= d;
        wb_sel <= s;
        n = 0;
        do
        begin
            @(posedge ref_clk_in);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 20);
        q = wb_rdat;
        chk({31'h0, wb_ack}, 32'h1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0, 4'hF);
        chk(q, exp);
    endtask
    // Bounded waits; a lost event shows as a mismatch, not a hang
    task automatic wait_run;
        int n;
        for (n = 0; n < 50 && halted !== 1'b0; n++) @(posedge ref_clk_in);
        chk({31'h0, halted}, 32'h0);
    endtask
    task automatic wait_stb;
        int n;
        for (n = 0; n < 100 && f_stb !== 1'b1; n++) @(posedge ref_clk_in);
        chk({31'h0, f_stb}, 32'h1);
    endtask
    initial
    begin
        #(crt_pkg::CLK_PERIOD_NS * 20000);
        bad_count++;
        summarize();
    end
    initial
    begin
        {rst_n_in, wb_cyc, wb_stb, wb_we, clk_en, float_req, stall} = '0;
        {wb_adr, wb_sel, wb_wdat} = '0;
        hold_low = 1'b1;
        {bad_count, n_checks, n_b, n_m} = '0;
        repeat (20) @(posedge ref_clk_in);
        rst_n_in <= 1'b1;
        clk_en <= 1'b1;
        rd(crt_pkg::ADR_STATUS, 32'h0);
        wb(1'b1, 6'h3C, 32'hFFFF_FFFF, 4'hF);
        rd(6'h3C, 32'h0);
        wb(1'b1, crt_pkg::ADR_STATUS, 32'hFFFF_FFFF, 4'hF);
        rd(crt_pkg::ADR_STATUS, 32'h0);
        $display("T1 halted state done");
        wb(1'b1, crt_pkg::ADR_PC, 32'hFF00_0123, 4'hF);
        wb(1'b1, crt_pkg::ADR_SIO_CFG, 32'h1234_56AB, 4'h1);
        rd(crt_pkg::ADR_SIO_CFG, 32'h0000_00AB);
        wb(1'b1, crt_pkg::ADR_ERR_STAT, 32'h0000_1234, 4'hF);
        wb(1'b1, crt_pkg::ADR_ERR_MASK, 32'h0, 4'hF);
        wb(1'b1, crt_pkg::ADR_PAR_CTRL, 32'h0000_00F0, 4'hF);
        wb(1'b1, crt_pkg::ADR_WAIT_CTRL, 32'h0000_0007, 4'hF);
        wb(1'b1, crt_pkg::ADR_COND_FLAGS, 32'hFFFF_A5A5, 4'hF);
        wb(1'b1, crt_pkg::ADR_FLOAT_CTRL, 32'h0000_5A5A, 4'hF);
        hold_low <= 1'b0;
        wait_run();
        wait_stb();
        chk(32'(f_addr), 32'h0);
        rd(crt_pkg::ADR_SAVED, 32'h0000_0123);
        rd(crt_pkg::ADR_SIO_CFG, 32'h0);
        rd(crt_pkg::ADR_ERR_STAT, 32'h0);
        rd(crt_pkg::ADR_ERR_MASK, 32'h0000_FFFF);
        rd(crt_pkg::ADR_PAR_CTRL, 32'h0000_0001);
        rd(crt_pkg::ADR_WAIT_CTRL, 32'h0000_0002);
        rd(crt_pkg::ADR_COND_FLAGS, 32'h0000_A5A5);
        rd(crt_pkg::ADR_FLOAT_CTRL, 32'h0000_5A5A);
        rd(crt_pkg::ADR_STATUS, 32'h0000_000B);
        $display("T2 reset sequence done");
        stall <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        cnt = 0;
        repeat (30) @(posedge ref_clk_in) if (f_stb === 1'b1) cnt++;
        chk(32'(cnt), 32'h0);
        stall <= 1'b0;
        wait_stb();
        $display("T3 ready stall done");
        float_req <= 1'b1;
        repeat (5) @(posedge ref_clk_in);
        chk({30'h0, bclk_oe_n, f_oe_n}, 32'h3);
        rd(crt_pkg::ADR_STATUS, 32'h0000_000F);
        float_req <= 1'b0;
        repeat (5) @(posedge ref_clk_in);
        chk({30'h0, bclk_oe_n, f_oe_n}, 32'h0);
        rd(crt_pkg::ADR_STATUS, 32'h0000_000B);
        $display("T4 float done");
        n_b = 0;
        n_m = 0;
        repeat (200) @(posedge ref_clk_in);
        chk({31'h0, (n_m - n_b) inside {0, 1} && n_b > 20}, 32'h1);
        $display("T5 clock done");
        hold_low <= 1'b1;
        repeat (8) @(posedge ref_clk_in);
        chk({31'h0, halted}, 32'h1);
        rd(crt_pkg::ADR_STATUS, 32'h0);
        wb(1'b1, crt_pkg::ADR_PC, 32'h00AB_CDEF, 4'hF);
        hold_low <= 1'b0;
        wait_run();
        wait_stb();
        chk(32'(f_addr), 32'h0);
        rd(crt_pkg::ADR_SAVED, 32'h00AB_CDEF);
        $display("T6 second halt done");
        summarize();
    end
endmodule
bind crt_ctrl crt_ctrl_assertions #(.PC_W(PC_W)) u_chk (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_ack_out(wb_ack_out),
    .master_clock_in(master_clock_in), .halt_reset_n_in(halt_reset_n_in),
    .tristate_all_n_in(tristate_all_n_in), .buffered_clock_out(buffered_clock_out),
    .buffered_clock_oe_n_out(buffered_clock_oe_n_out), .fetch_addr_out(fetch_addr_out),
    .fetch_strobe_out(fetch_strobe_out), .fetch_oe_n_out(fetch_oe_n_out),
    .halted_out(halted_out));
`default_nettype wire
